// ---- byte_fifo.sv ----
`timescale 1ns/1ps
// Small synchronous byte FIFO with push/pop and level flags
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] data_o,
  output logic                  empty_o,
  output logic                  full_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  // Push into a full FIFO or pop from empty is dropped
  assign do_push = push_i && (count != (AW+1)'(DEPTH));
  assign do_pop  = pop_i && (count != '0);
  assign data_o  = store[rptr];
  assign empty_o = (count == '0);
  assign full_o  = (count == (AW+1)'(DEPTH));

  // Storage needs no reset; flags guard every read
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      store[wptr] <= data_i;
    end
  end

  // Pointers wrap at DEPTH
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
      end
      if (do_pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// ---- radio_slave_model.sv ----
`timescale 1ns/1ps
// **********************************
// Radio link slave model
// **********************************
module radio_slave_model #(
  parameter logic [7:0] STATUS_BYTE = 8'h0E
) (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       csn_i,
  output logic            miso_o,
  output logic [7:0]      last_rx_o
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int         bit_cnt;

  // Quiet start
  initial begin
    miso_o    = 1'b0;
    last_rx_o = 8'h00;
    tx_sh     = 8'h00;
    rx_sh     = 8'h00;
    bit_cnt   = 0;
  end

  always @(negedge csn_i) begin
    tx_sh   = STATUS_BYTE;
    bit_cnt = 0;
    miso_o  = tx_sh[7];
  end

  // Released line must not keep the old bit
  always @(posedge csn_i) begin
    miso_o = ~miso_o;
  end

  always @(posedge sck_i) begin
    if (!csn_i) begin
      rx_sh   = {rx_sh[6:0], mosi_i};
      bit_cnt = bit_cnt + 1;
    end
  end

  // change on fall; later bytes echo the previous one
  always @(negedge sck_i) begin
    if (!csn_i) begin
      if (bit_cnt == 8) begin
        last_rx_o = rx_sh;
        tx_sh     = rx_sh;
        bit_cnt   = 0;
      end else begin
        tx_sh = {tx_sh[6:0], 1'b0};
      end
      miso_o = tx_sh[7];
    end
  end
endmodule

// ---- radio_spi_master_sfr.sv ----
`timescale 1ns/1ps
// SFR-mapped SPI master toward the embedded radio
module radio_spi_master_sfr
  import radio_spi_pkg::*;
(
  input  wire logic                      clock_i,
  input  wire logic                      nrst_i,
  input  wire radio_spi_pkg::sfr_req_t   sfr_i,
  input  wire logic                      miso_i,
  output logic [7:0]                     rdata_o,
  output logic                           irq_o,
  output radio_spi_pkg::radio_pins_t     radio_o
);
  import radio_spi_pkg::*;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [6:0] link_config_reserved;
  logic [3:0] fifo_irq_mask;
  logic [2:0] radio_select_enable_ctrl;
  logic [3:0] fifo_condition_flags;

  logic       tx_push;
  logic       tx_pop;
  logic [7:0] tx_head;
  logic       tx_empty;
  logic       tx_full;
  logic       rx_push;
  logic       rx_pop;
  logic [7:0] rx_head;
  logic       rx_empty;
  logic       rx_full;
  logic       sh_busy;
  logic       sh_done;
  logic       sh_start;
  logic [7:0] sh_rx;
  logic       sck;
  logic       mosi;
  logic [3:0] next_flags;

  // Register decode used by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // R13 data port push/pop
  assign tx_push = sfr_i.wr && hit(sfr_i.addr, ADDR_BYTE_PORT);
  assign rx_pop  = sfr_i.rd && hit(sfr_i.addr, ADDR_BYTE_PORT);

  // Done cycle skipped: its byte is not yet counted in rx
  // R21 start only when rx has room, so no byte is ever lost
  assign sh_start = !sh_busy && !sh_done && !tx_empty && !rx_full;
  assign tx_pop   = sh_start;
  assign rx_push  = sh_done;

  // ************************************************************
  // FIFOs and shifter
  // ************************************************************
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .push_i  (tx_push),
    .data_i  (sfr_i.wdata),
    .pop_i   (tx_pop),
    .data_o  (tx_head),
    .empty_o (tx_empty),
    .full_o  (tx_full)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .push_i  (rx_push),
    .data_i  (sh_rx),
    .pop_i   (rx_pop),
    .data_o  (rx_head),
    .empty_o (rx_empty),
    .full_o  (rx_full)
  );

  // R19 first byte back is the radio status
  spi_shifter u_shift (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .start_i   (sh_start),
    .tx_byte_i (tx_head),
    .miso_i    (miso_i),
    .busy_o    (sh_busy),
    .done_o    (sh_done),
    .rx_byte_o (sh_rx),
    .sck_o     (sck),
    .mosi_o    (mosi)
  );

  // ************************************************************
  // Writable registers
  // ************************************************************

  // R1 reserved bits hold their value, steer nothing
  // R2 mask resets all masked
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_config_reserved     <= RST_CONFIG_RSVD;
      fifo_irq_mask            <= RST_IRQ_MASK;
      radio_select_enable_ctrl <= RST_RADIO_CTRL;
    end else if (sfr_i.wr) begin
      if (hit(sfr_i.addr, ADDR_CONFIG_RSVD)) begin
        link_config_reserved <= sfr_i.wdata[6:0];
      end
      if (hit(sfr_i.addr, ADDR_IRQ_MASK)) begin
        fifo_irq_mask <= sfr_i.wdata[3:0];
      end
      if (hit(sfr_i.addr, ADDR_RADIO_CTRL)) begin
        radio_select_enable_ctrl <= sfr_i.wdata[2:0];
      end
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************

  // R8 R9 R10 flags from FIFO levels
  always_comb begin
    next_flags               = 4'h0;
    next_flags[BIT_RX_FULL]  = rx_full;
    next_flags[BIT_RX_DATA]  = !rx_empty;
    next_flags[BIT_TX_EMPTY] = tx_empty;
    next_flags[BIT_TX_ROOM]  = !tx_full;
  end

  // R11 flags track state, no acknowledge
  // R12 reset value 0x03
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fifo_condition_flags <= RST_FLAGS;
    end else begin
      fifo_condition_flags <= next_flags;
    end
  end

  // R3 R4 R5 R6 R7 unmasked sources drive irq
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_flags & ~fifo_irq_mask);
    end
  end

  // ************************************************************
  // Read data, registered; unmapped reads give zero
  // ************************************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (sfr_i.rd) begin
      case (sfr_i.addr)
        ADDR_CONFIG_RSVD: rdata_o <= {1'b0, link_config_reserved};
        ADDR_IRQ_MASK:    rdata_o <= {4'h0, fifo_irq_mask};
        ADDR_FLAGS:       rdata_o <= {4'h0, fifo_condition_flags};
        ADDR_BYTE_PORT:   rdata_o <= rx_empty ? 8'h00 : rx_head;
        ADDR_RADIO_CTRL:  rdata_o <= {5'h00, radio_select_enable_ctrl};
        default:          rdata_o <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Radio pins, registered
  // ************************************************************

  // R15 R16 R17 control bits to pins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      radio_o <= '{sck: 1'b0, mosi: 1'b0, csn: 1'b1, ce: 1'b0,
                   radio_clock_enable_line: 1'b0};
    end else begin
      radio_o.sck  <= sck;
      radio_o.mosi <= mosi;
      radio_o.radio_clock_enable_line <= radio_select_enable_ctrl[BIT_CLK_EN];
      radio_o.csn  <= radio_select_enable_ctrl[BIT_SEL_N];
      radio_o.ce   <= radio_select_enable_ctrl[BIT_CHIP_EN];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_start;
    sh_start;
  endsequence

  sequence s_byte_back;
    ##[1:200] sh_done;
  endsequence

  a_irq_mask_gate: assert property (  // R7
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 irq_o == |($past(next_flags) & ~$past(fifo_irq_mask)))
    else $error("interrupt does not follow unmasked flags");

  a_mask_reset_hold: assert property (  // R2
    @(posedge clock_i) disable iff (!nrst_i)
    !(sfr_i.wr && hit(sfr_i.addr, ADDR_IRQ_MASK)) |=> $stable(fifo_irq_mask))
    else $error("mask changed without a write");

  a_rx_full_flag: assert property (  // R8
    @(posedge clock_i) disable iff (!nrst_i)
    rx_full |=> fifo_condition_flags[BIT_RX_FULL])
    else $error("rx full flag missing");

  a_rx_data_flag: assert property (  // R9
    @(posedge clock_i) disable iff (!nrst_i)
    !rx_empty |=> fifo_condition_flags[BIT_RX_DATA])
    else $error("rx data flag missing");

  a_tx_flags: assert property (  // R10
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 fifo_condition_flags[1:0] == {$past(tx_empty), !$past(tx_full)})
    else $error("tx flags wrong");

  a_no_rx_overrun: assert property (  // R21
    @(posedge clock_i) disable iff (!nrst_i)
    sh_done |-> !rx_full)
    else $error("byte finished with rx full");

  a_byte_returns: assert property (  // R13
    @(posedge clock_i) disable iff (!nrst_i)
    s_start |-> s_byte_back)
    else $error("transfer did not finish");

  a_sck_idle_low: assert property (  // R22
    @(posedge clock_i) disable iff (!nrst_i)
    !sh_busy |-> !sck)
    else $error("clock not idle low");

  a_select_follows: assert property (  // R16
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 radio_o.csn == $past(radio_select_enable_ctrl[BIT_SEL_N]))
    else $error("select pin does not follow control");

  // Clock phases of one bit, four system cycles each
  sequence s_sck_high;
    sck [*4] ##1 !sck;
  endsequence

  sequence s_sck_low;
    !sck [*4] ##1 sck;
  endsequence

  a_sck_high_phase: assert property (  // R22
    @(posedge clock_i) disable iff (!nrst_i)
    $rose(sck) |-> s_sck_high)
    else $error("clock high phase has wrong length");

  a_sck_low_phase: assert property (  // R22
    @(posedge clock_i) disable iff (!nrst_i)
    $fell(sck) && sh_busy |-> s_sck_low)
    else $error("clock low phase has wrong length");

  a_mosi_steady_high: assert property (  // R22
    @(posedge clock_i) disable iff (!nrst_i)
    sck |-> $stable(mosi))
    else $error("data changed while clock high");

  a_clock_enable_pin: assert property (  // R15
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 radio_o.radio_clock_enable_line ==
        $past(radio_select_enable_ctrl[BIT_CLK_EN]))
    else $error("clock enable pin does not follow control");

  a_chip_enable_pin: assert property (  // R17
    @(posedge clock_i) disable iff (!nrst_i)
    ##1 radio_o.ce == $past(radio_select_enable_ctrl[BIT_CHIP_EN]))
    else $error("chip enable pin does not follow control");

  a_rx_full_clear: assert property (  // R11
    @(posedge clock_i) disable iff (!nrst_i)
    !rx_full |=> !fifo_condition_flags[BIT_RX_FULL])
    else $error("rx full flag stuck");

  a_rx_data_clear: assert property (  // R11
    @(posedge clock_i) disable iff (!nrst_i)
    rx_empty |=> !fifo_condition_flags[BIT_RX_DATA])
    else $error("rx data flag stuck");

  a_read_pops_head: assert property (  // R13
    @(posedge clock_i) disable iff (!nrst_i)
    rx_pop && !rx_empty |=> rdata_o == $past(rx_head))
    else $error("data read is not the oldest rx byte");

  a_tx_push_lands: assert property (  // R13
    @(posedge clock_i) disable iff (!nrst_i)
    tx_push && !tx_full |=> !tx_empty)
    else $error("written byte missing from tx");

  a_irq_all_masked: assert property (  // R2
    @(posedge clock_i) disable iff (!nrst_i)
    fifo_irq_mask == RST_IRQ_MASK |=> !irq_o)
    else $error("interrupt raised while fully masked");
endmodule

// ---- radio_spi_master_sfr_tb_top.sv ----
`timescale 1ns/1ps
module radio_spi_master_sfr_tb_top;
  import radio_spi_pkg::*;
  localparam logic [7:0] STAT = 8'h0E;
  logic        clock_i;
  logic        nrst_i;
  sfr_req_t    sfr;
  logic        miso;
  logic [7:0]  rdata;
  logic        irq;
  radio_pins_t pins;
  logic [7:0]  slave_rx;
  logic [7:0]  rd_val;
  int          mismatches;
  int          cmp_count;

  // **********************************
  // Instances
  // **********************************
  radio_spi_master_sfr u_radio_spi_master_sfr (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .sfr_i   (sfr),
    .miso_i  (miso),
    .rdata_o (rdata),
    .irq_o   (irq),
    .radio_o (pins)
  );
  radio_slave_model #(.STATUS_BYTE(STAT)) u_radio_slave_model (
    .sck_i     (pins.sck),
    .mosi_i    (pins.mosi),
    .csn_i     (pins.csn),
    .miso_o    (miso),
    .last_rx_o (slave_rx)
  );

  // 10 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // **********************************
  // Shared tasks
  // **********************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bus cycles start and end just after a falling edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock_i);
    sfr.wr = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic sfr_rd(input logic [7:0] a);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_i);
    sfr.rd = 1'b0;
    @(negedge clock_i);
    rd_val = rdata;
  endtask

  // software paces itself by the flags; bounded poll
  task automatic wait_flags(input logic [7:0] exp);
    for (int n = 0; n < 400; n++) begin
      sfr_rd(ADDR_FLAGS);
      if (rd_val === exp) return;
    end
    mismatches++;
    $display("Error at %0t: flags %h expected %h", $time, rd_val, exp);
    close_out();
  endtask

  task automatic irq_case(input logic [7:0] mask, input logic exp);
    sfr_wr(ADDR_IRQ_MASK, mask);
    repeat (3) @(negedge clock_i);
    check({7'h00, irq}, {7'h00, exp});
  endtask

  // **********************************
  // Scenarios
  // **********************************
  task automatic t_reset();
    sfr_rd(ADDR_CONFIG_RSVD); check(rd_val, 8'h01);
    sfr_rd(ADDR_IRQ_MASK); check(rd_val, 8'h0F);
    sfr_rd(ADDR_FLAGS); check(rd_val, 8'h03);
    sfr_rd(ADDR_BYTE_PORT); check(rd_val, 8'h00);
    sfr_rd(8'hE0); check(rd_val, 8'h00);
    check({7'h00, irq}, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_ctrl();
    for (int i = 0; i < 8; i++) begin
      sfr_wr(ADDR_RADIO_CTRL, 8'(i));
      repeat (2) @(negedge clock_i);
      check({5'h00, pins.radio_clock_enable_line, pins.csn, pins.ce},
            8'(i));
    end
    sfr_wr(ADDR_RADIO_CTRL, 8'h02);
    $display("t_ctrl done");
  endtask

  task automatic t_irq_idle();
    irq_case(8'h0D, 1'b1);
    irq_case(8'h0E, 1'b1);
    irq_case(8'h03, 1'b0);
    sfr_wr(ADDR_IRQ_MASK, 8'h0F);
    $display("t_irq_idle done");
  endtask

  task automatic t_command();
    sfr_wr(ADDR_RADIO_CTRL, 8'h05);
    sfr_wr(ADDR_BYTE_PORT, 8'hA5);
    wait_flags(8'h07); check(rd_val, 8'h07);
    check(slave_rx, 8'hA5);
    sfr_rd(ADDR_BYTE_PORT); check(rd_val, STAT);
    wait_flags(8'h03); check(rd_val, 8'h03);
    $display("t_command done");
  endtask

  task automatic t_full();
    sfr_wr(ADDR_BYTE_PORT, 8'h11);
    sfr_wr(ADDR_BYTE_PORT, 8'h22);
    sfr_wr(ADDR_BYTE_PORT, 8'h33);
    wait_flags(8'h0D); check(rd_val, 8'h0D);
    repeat (80) @(negedge clock_i);
    check(slave_rx, 8'h22);
    irq_case(8'h07, 1'b1);
    irq_case(8'h0B, 1'b1);
    irq_case(8'h0D, 1'b0);
    irq_case(8'h0F, 1'b0);
    sfr_rd(ADDR_BYTE_PORT); check(rd_val, 8'hA5);
    sfr_rd(ADDR_BYTE_PORT); check(rd_val, 8'h11);
    wait_flags(8'h07); check(slave_rx, 8'h33);
    sfr_rd(ADDR_BYTE_PORT); check(rd_val, 8'h22);
    wait_flags(8'h03); check(rd_val, 8'h03);
    sfr_wr(ADDR_RADIO_CTRL, 8'h02);
    $display("t_full done");
  endtask

  // Main sequence
  initial begin
    mismatches = 0;
    cmp_count  = 0;
    rd_val     = 8'h00;
    nrst_i     = 1'b0;
    sfr        = '0;
    repeat (20) @(negedge clock_i);
    nrst_i = 1'b1;
    @(negedge clock_i);
    check({7'h00, pins.csn}, 8'h01);
    t_reset();
    t_ctrl();
    t_irq_idle();
    t_command();
    t_full();
    close_out();
  end
endmodule

// ---- radio_spi_pkg.sv ----
// Operation
// R1 - Reserved config bits reset 0x01, unused
// R2 - Interrupt mask resets to 0x0F
// R3 - Mask bit 3 gates rx full
// R4 - Mask bit 2 gates rx data present
// R5 - Mask bit 1 gates tx empty
// R6 - Mask bit 0 gates tx room
// R7 - Any unmasked active source raises interrupt
// R8 - Status bit 3 shows rx full
// R9 - Status bit 2 shows rx data present
// R10 - Status bits 1,0 show tx empty, room
// R11 - Status flags follow FIFO state directly
// R12 - Status reads 0x03 after reset
// R13 - Data write pushes tx, read pops rx
// R14 - Software refills/drains by the flags
// R15 - Control bit 2 enables radio clock
// R16 - Control bit 1 drives select, low active
// R17 - Control bit 0 drives chip enable
// R18 - Software lowers select before command byte
// R19 - First byte returned is radio status
// R20 - Bytes shift most significant bit first
// R21 - Shift tx bytes while rx has room
// R22 - Clock idles low, sample rising edge
package radio_spi_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_CONFIG_RSVD = 8'hE4;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'hE5;
  localparam logic [7:0] ADDR_FLAGS       = 8'hE6;
  localparam logic [7:0] ADDR_BYTE_PORT   = 8'hE7;
  localparam logic [7:0] ADDR_RADIO_CTRL  = 8'hE8;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [6:0] RST_CONFIG_RSVD = 7'h01;
  localparam logic [3:0] RST_IRQ_MASK    = 4'hF;
  localparam logic [3:0] RST_FLAGS       = 4'h3;
  localparam logic [2:0] RST_RADIO_CTRL  = 3'h2;
  localparam int BIT_RX_FULL   = 3;
  localparam int BIT_RX_DATA   = 2;
  localparam int BIT_TX_EMPTY  = 1;
  localparam int BIT_TX_ROOM   = 0;
  localparam int BIT_CLK_EN    = 2;
  localparam int BIT_SEL_N     = 1;
  localparam int BIT_CHIP_EN   = 0;

  // ************************************************************
  // Timing and FIFO depth
  // ************************************************************
  localparam int CLK_NS       = 100;
  localparam int HALF_SCK_NS  = 400;
  localparam int HALF_SCK_CYC = (HALF_SCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_DEPTH   = 2;

  // Special function register access from the CPU
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Pins toward the radio
  typedef struct packed {
    logic sck;
    logic mosi;
    logic csn;
    logic ce;
    logic radio_clock_enable_line;
  } radio_pins_t;

endpackage

// ---- spi_shifter.sv ----
`timescale 1ns/1ps
// Mode 0 byte shifter: clock idle low, MSB first
module spi_shifter
  import radio_spi_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       miso_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rx_byte_o,
  output logic            sck_o,
  output logic            mosi_o
);
  typedef enum logic [1:0] {IDLE, LOW, HIGH} shift_state_t;

  shift_state_t state;
  logic [7:0]   shreg;
  logic [2:0]   bits;
  logic [3:0]   tick;
  logic         miso_s1;
  logic         miso_s2;
  logic         tick_end;

  assign tick_end  = (tick == 4'(HALF_SCK_CYC - 1));
  assign busy_o    = (state != IDLE);
  assign rx_byte_o = shreg;

  // Two-stage sync of the serial input
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
    end
  end

  // R20 MSB first shifting
  // R22 idle low, sample rising
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state  <= IDLE;
      shreg  <= 8'h00;
      bits   <= 3'h0;
      tick   <= 4'h0;
      sck_o  <= 1'b0;
      mosi_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        IDLE: begin
          sck_o <= 1'b0;
          if (start_i) begin
            shreg  <= {tx_byte_i[6:0], 1'b0};
            mosi_o <= tx_byte_i[7];
            bits   <= 3'h0;
            tick   <= 4'h0;
            state  <= LOW;
          end
        end
        LOW: begin
          tick <= tick_end ? 4'h0 : tick + 4'h1;
          if (tick_end) begin
            sck_o    <= 1'b1;
            shreg[0] <= miso_s2;
            state    <= HIGH;
          end
        end
        HIGH: begin
          tick <= tick_end ? 4'h0 : tick + 4'h1;
          if (tick_end) begin
            sck_o <= 1'b0;
            if (bits == 3'h7) begin
              done_o <= 1'b1;
              state  <= IDLE;
            end else begin
              mosi_o <= shreg[7];
              shreg  <= {shreg[6:0], 1'b0};
              bits   <= bits + 3'h1;
              state  <= LOW;
            end
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule
